// ==== sac_dma_if.sv ====
// link between the sweep controller and its word mover
`timescale 1ns/1ps
interface sac_dma_if;
  logic        start;
  logic [15:0] base;
  logic [15:0] word0;
  logic [15:0] word1;
  logic        done;
  logic        drv;
  logic [15:0] addr;
  logic [15:0] data;
  modport ctrl  (output start, output base, output word0, output word1,
                 input done, input drv, input addr, input data);
  modport mover (input start, input base, input word0, input word1,
                 output done, output drv, output addr, output data);
endinterface : sac_dma_if

// ==== sac_pkg.sv ====
// constants and the sync word function shared by the sweep acquisition controller modules
// Notes on behaviour
// - one interrupt raised per detected sync
// - each accepted request moves exactly two words; a refused one moves none
// - first pair after sync is sweep header
// - later pairs carry reply data
// - at most 64 words between syncs
// - fresh start address required before first request
// - previous sweep reply count in sync word
// - no drive while processor uses memory
// - sixteen bidirectional data lines on bus
// - vector placed on data lines at acknowledge
// - drive memory address lines during writes
// - one memory cycle per steal, then release
package sac_pkg;
  // -----------------------------------------------------------------
  // widths and limits
  // -----------------------------------------------------------------
  localparam int unsigned SAC_WORD_W    = 16;
  localparam int unsigned SAC_CNT_W     = 8;
  localparam int unsigned SAC_WCNT_W    = 7;
  localparam logic [6:0]  SAC_MAX_WORDS = 7'h40;
  localparam logic [6:0]  SAC_PAIR      = 7'h02;
  localparam logic [7:0]  SAC_CNT_MAX   = 8'hFF;
  // -----------------------------------------------------------------
  // sync word layout and reset values
  // -----------------------------------------------------------------
  localparam int unsigned SAC_SW_ERR_BIT = 15;
  localparam int unsigned SAC_SW_CNT_LSB = 0;
  localparam logic [15:0] SAC_ZERO_WORD  = 16'h0000;
  localparam logic [7:0]  SAC_ZERO_CNT   = 8'h00;
  localparam logic [6:0]  SAC_ZERO_WCNT  = 7'h00;
  // arbitrary vector value, set per installation
  localparam logic [15:0] SAC_VECTOR_DEF = 16'h0040;

  // build the sync word from error flag and reply count
  function automatic logic [15:0] sac_sync_word(input logic err, input logic [7:0] cnt);
    logic [15:0] w;
    w = SAC_ZERO_WORD;
    w[SAC_SW_ERR_BIT] = err;
    w[SAC_SW_CNT_LSB +: SAC_CNT_W] = cnt;
    return w;
  endfunction : sac_sync_word
endpackage : sac_pkg

// ==== sac_src_model.sv ====
// acquisition source model: sync pulses and word pair requests
`timescale 1ns/1ps
module sac_src_model
(
  input  wire logic        ref_clk,
  input  wire logic        src_ack,
  output      logic        src_sync,
  output      logic        src_req,
  output      logic [15:0] src_word0,
  output      logic [15:0] src_word1
);
  // acknowledges seen, read by the bench
  int ack_seen = 0;

  // pins idle low until a task drives them
  initial
  begin
    src_sync  = 1'b0;
    src_req   = 1'b0;
    src_word0 = 16'h0000;
    src_word1 = 16'h0000;
  end

  // sync held long enough to cross the input synchronisers
  task automatic send_sync();
    src_sync = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 src_sync = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : send_sync

  // words stand while the request is up; hold makes a slow source
  task automatic send_pair(input logic [15:0] w0, input logic [15:0] w1, input int hold);
    int n;
    src_word0 = w0;
    src_word1 = w1;
    src_req   = 1'b1;
    for (n = 0; n < 200 && src_ack !== 1'b1; n++)
    begin
      @(posedge ref_clk);
      #1;
    end
    if (src_ack === 1'b1) ack_seen++;
    repeat (hold + 1) @(posedge ref_clk);
    #1 src_req = 1'b0;
    // released words show garbage, not the last pair
    src_word0 = ~w0;
    src_word1 = ~w1;
    for (n = 0; n < 200 && src_ack !== 1'b0; n++)
    begin
      @(posedge ref_clk);
      #1;
    end
  endtask : send_pair
endmodule : sac_src_model

// ==== sac_word_mover.sv ====
// moves one word pair into memory by stolen single cycles
`timescale 1ns/1ps
module sac_word_mover
(
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic bus_busy,
  input  wire logic dma_grant,
  output      logic dma_req,
  output      logic bus_wr,
  sac_dma_if.mover  lnk
);
  typedef enum logic [2:0] {SAC_M_IDLE = 3'h1, SAC_M_ARB = 3'h2, SAC_M_WR = 3'h4} sac_m_type;
  sac_m_type   state;
  logic        idx;
  logic [15:0] w1;
  logic [1:0]  wr_cnt;
  logic [15:0] wr0_addr;

  // -----------------------------------------------------------------
  // cycle stealing sequencer
  // -----------------------------------------------------------------
  // request released after every word so others get the memory
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      state    <= SAC_M_IDLE;
      idx      <= 1'b0;
      w1       <= sac_pkg::SAC_ZERO_WORD;
      lnk.addr <= sac_pkg::SAC_ZERO_WORD;
      lnk.data <= sac_pkg::SAC_ZERO_WORD;
      lnk.drv  <= 1'b0;
      lnk.done <= 1'b0;
    end
    else
    begin
      lnk.done <= 1'b0;
      case (state)
        SAC_M_IDLE:
        begin
          lnk.drv <= 1'b0;
          if (lnk.start)
          begin
            lnk.addr <= lnk.base;
            lnk.data <= lnk.word0;
            w1       <= lnk.word1;
            idx      <= 1'b0;
            state    <= SAC_M_ARB;
          end
        end
        SAC_M_ARB:
        begin
          if (dma_grant && !bus_busy)
          begin
            lnk.drv <= 1'b1;
            state   <= SAC_M_WR;
          end
        end
        SAC_M_WR:
        begin
          lnk.drv <= 1'b0;
          if (idx)
          begin
            lnk.done <= 1'b1;
            state    <= SAC_M_IDLE;
          end
          else
          begin
            idx      <= 1'b1;
            lnk.addr <= lnk.addr + 16'h0001;
            lnk.data <= w1;
            state    <= SAC_M_ARB;
          end
        end
        default: state <= SAC_M_IDLE;
      endcase
    end
  end

  assign dma_req = (state == SAC_M_ARB);
  assign bus_wr  = lnk.drv;

  // helper: writes seen in the current pair
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      wr_cnt <= 2'h0;
    else if (lnk.start && state == SAC_M_IDLE)
      wr_cnt <= 2'h0;
    else if (bus_wr)
      wr_cnt <= wr_cnt + 2'h1;
  end

  // helper: address of the first word, so the second can be judged against it
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      wr0_addr <= sac_pkg::SAC_ZERO_WORD;
    else if (bus_wr && !idx)
      wr0_addr <= lnk.addr;
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  AST_TWO_WORDS: assert property (@(posedge ref_clk) disable iff (!rst_b)
    lnk.done |-> wr_cnt == 2'h2) else $error("pair did not write two words");
  AST_ADDR_STEP: assert property (@(posedge ref_clk) disable iff (!rst_b)
    bus_wr && idx |-> lnk.addr == wr0_addr + 16'h0001) else $error("second word address wrong");
  AST_NO_BUSY_DRIVE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    bus_wr |-> !$past(bus_busy) && $past(dma_grant)) else $error("drove bus without grant");
  AST_ONE_CYCLE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    bus_wr |=> !bus_wr) else $error("held memory beyond one cycle");
  COV_PAIR: cover property (@(posedge ref_clk) disable iff (!rst_b) lnk.done);
endmodule : sac_word_mover

// ==== sweep_acquisition_controller.sv ====
// sweep acquisition controller: sync, checks, counts and bus answers
`timescale 1ns/1ps
module sweep_acquisition_controller
#(
  parameter logic [15:0] VECTOR = sac_pkg::SAC_VECTOR_DEF
)
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // acquisition source pins
  input  wire logic        src_sync,
  input  wire logic        src_req,
  input  wire logic [15:0] src_word0,
  input  wire logic [15:0] src_word1,
  output      logic        src_ack,
  // processor side
  input  wire logic        bus_busy,
  output      logic        irq,
  input  wire logic        irq_ack,
  input  wire logic        start_addr_wr,
  input  wire logic        sync_word_rd,
  input  wire logic        dma_grant,
  output      logic        dma_req,
  output      logic        bus_wr,
  input  wire logic [15:0] bus_data_in,
  output      logic [15:0] bus_data_out,
  output      logic        bus_data_oe_n,
  output      logic [15:0] bus_addr_out,
  output      logic        bus_addr_oe_n,
  output      logic        err_flag
);
  typedef enum logic [2:0] {SAC_T_IDLE = 3'h1, SAC_T_MOVE = 3'h2, SAC_T_ACK = 3'h4} sac_t_type;

  sac_dma_if   lnk ();
  sac_t_type   state;
  logic [1:0]  sync_ff;
  logic [1:0]  req_ff;
  logic [15:0] w0_m, w0_s, w1_m, w1_s;
  logic        sync_d;
  logic        sync_evt;
  logic        take;
  logic        fits;
  logic        refuse;
  logic        addr_fresh;
  logic        first_pair;
  logic        err_armed;
  logic [15:0] next_addr;
  logic [6:0]  words;
  logic [7:0]  reply_cnt;
  logic [7:0]  prev_cnt;
  logic        host_drv;
  logic [15:0] host_data;

  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  // words are sampled through the same depth as the request
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      sync_ff <= 2'h0;
      req_ff  <= 2'h0;
      w0_m    <= sac_pkg::SAC_ZERO_WORD;
      w0_s    <= sac_pkg::SAC_ZERO_WORD;
      w1_m    <= sac_pkg::SAC_ZERO_WORD;
      w1_s    <= sac_pkg::SAC_ZERO_WORD;
      sync_d  <= 1'b0;
    end
    else
    begin
      sync_ff <= {sync_ff[0], src_sync};
      req_ff  <= {req_ff[0], src_req};
      w0_m    <= src_word0;
      w0_s    <= w0_m;
      w1_m    <= src_word1;
      w1_s    <= w1_m;
      sync_d  <= sync_ff[1];
    end
  end

  assign sync_evt = sync_ff[1] && !sync_d;
  assign take     = (state == SAC_T_IDLE) && req_ff[1];
  assign fits     = (words + sac_pkg::SAC_PAIR) <= sac_pkg::SAC_MAX_WORDS;
  assign refuse   = take && (!addr_fresh || !fits);

  // -----------------------------------------------------------------
  // request sequencer
  // -----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      state <= SAC_T_IDLE;
    else
    begin
      case (state)
        SAC_T_IDLE: if (take) state <= refuse ? SAC_T_ACK : SAC_T_MOVE;
        SAC_T_MOVE: if (lnk.done) state <= SAC_T_ACK;
        SAC_T_ACK:  if (!req_ff[1]) state <= SAC_T_IDLE;
        default:    state <= SAC_T_IDLE;
      endcase
    end
  end

  assign src_ack   = (state == SAC_T_ACK);
  assign lnk.start = take && !refuse;
  assign lnk.base  = next_addr;
  assign lnk.word0 = w0_s;
  assign lnk.word1 = w1_s;

  // -----------------------------------------------------------------
  // interrupt and start address
  // -----------------------------------------------------------------
  // a sync landing with the acknowledge keeps the line up
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      irq <= 1'b0;
    else if (sync_evt)
      irq <= 1'b1;
    else if (irq_ack)
      irq <= 1'b0;
  end

  // address arrives from the processor answering the interrupt
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      next_addr  <= sac_pkg::SAC_ZERO_WORD;
      addr_fresh <= 1'b0;
    end
    else
    begin
      if (start_addr_wr)
        next_addr <= bus_data_in;
      else if (lnk.done)
        next_addr <= next_addr + {9'h000, sac_pkg::SAC_PAIR};
      if (start_addr_wr)
        addr_fresh <= 1'b1;
      else if (sync_evt)
        addr_fresh <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // sweep bookkeeping
  // -----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      words      <= sac_pkg::SAC_ZERO_WCNT;
      first_pair <= 1'b1;
      reply_cnt  <= sac_pkg::SAC_ZERO_CNT;
      prev_cnt   <= sac_pkg::SAC_ZERO_CNT;
    end
    else if (sync_evt)
    begin
      words      <= sac_pkg::SAC_ZERO_WCNT;
      first_pair <= 1'b1;
      reply_cnt  <= sac_pkg::SAC_ZERO_CNT;
      prev_cnt   <= reply_cnt;
    end
    else
    begin
      if (lnk.start)
        words <= words + sac_pkg::SAC_PAIR;
      if (take)
        first_pair <= 1'b0;
      // saturating: a runaway sweep must not wrap to a small count
      if (take && !first_pair && reply_cnt != sac_pkg::SAC_CNT_MAX)
        reply_cnt <= reply_cnt + 8'h01;
    end
  end

  // error stays until a sync and then a new address; set wins
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      err_flag  <= 1'b0;
      err_armed <= 1'b0;
    end
    else
    begin
      if (refuse)
        err_flag <= 1'b1;
      else if (start_addr_wr && err_armed)
        err_flag <= 1'b0;
      if (refuse)
        err_armed <= 1'b0;
      else if (sync_evt)
        err_armed <= 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // bus answers
  // -----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      host_drv  <= 1'b0;
      host_data <= sac_pkg::SAC_ZERO_WORD;
    end
    else
    begin
      host_drv <= (irq_ack || sync_word_rd) && !bus_busy;
      if (irq_ack)
        host_data <= VECTOR;
      else if (sync_word_rd)
        host_data <= sac_pkg::sac_sync_word(err_flag, prev_cnt);
    end
  end

  assign bus_data_out  = lnk.drv ? lnk.data : host_data;
  assign bus_data_oe_n = !(lnk.drv || host_drv);
  assign bus_addr_out  = lnk.addr;
  assign bus_addr_oe_n = !lnk.drv;

  sac_word_mover u_mover
  (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .bus_busy  (bus_busy),
    .dma_grant (dma_grant),
    .dma_req   (dma_req),
    .bus_wr    (bus_wr),
    .lnk       (lnk.mover)
  );

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  AST_IRQ_ON_SYNC: assert property (@(posedge ref_clk) disable iff (!rst_b)
    sync_evt |=> irq) else $error("sync without interrupt");
  AST_NO_ADDR_REFUSE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    take && !addr_fresh |=> err_flag && state == SAC_T_ACK) else $error("stale address served");
  AST_WORD_LIMIT: assert property (@(posedge ref_clk) disable iff (!rst_b)
    words <= sac_pkg::SAC_MAX_WORDS) else $error("sweep word limit exceeded");
  AST_PREV_COUNT: assert property (@(posedge ref_clk) disable iff (!rst_b)
    sync_evt |=> prev_cnt == $past(reply_cnt)) else $error("reply count not carried");
  AST_VECTOR: assert property (@(posedge ref_clk) disable iff (!rst_b)
    irq_ack && !bus_busy && !lnk.drv |=> !bus_data_oe_n && (lnk.drv || bus_data_out == VECTOR))
    else $error("vector not driven");
  AST_ERR_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_b)
    err_flag && !start_addr_wr |=> err_flag) else $error("error flag dropped");
  AST_ADDR_PAIR: assert property (@(posedge ref_clk) disable iff (!rst_b)
    lnk.done && !start_addr_wr |=> next_addr == $past(next_addr) + 16'h0002)
    else $error("address not advanced by pair");
  AST_REFUSED_NO_DMA: assert property (@(posedge ref_clk) disable iff (!rst_b)
    refuse |=> !dma_req [*2]) else $error("refused request moved data");
  COV_SWEEP: cover property (@(posedge ref_clk) disable iff (!rst_b) sync_evt ##[1:200] lnk.done);
  COV_REFUSE: cover property (@(posedge ref_clk) disable iff (!rst_b) refuse);
  COV_SYNCRD: cover property (@(posedge ref_clk) disable iff (!rst_b) sync_word_rd && !bus_busy);
endmodule : sweep_acquisition_controller

// ==== sweep_acquisition_controller_tb.sv ====
// self-checking bench for the sweep acquisition controller
`timescale 1ns/1ps
module sweep_acquisition_controller_tb;
  localparam logic [15:0] VEC  = 16'h0123;
  localparam logic [15:0] BASE = 16'h2000;
  logic        ref_clk, rst_b, src_sync, src_req, src_ack, bus_busy, irq, irq_ack;
  logic        start_addr_wr, sync_word_rd, dma_grant, dma_req, bus_wr;
  logic        bus_data_oe_n, bus_addr_oe_n, err_flag;
  logic [15:0] src_word0, src_word1, bus_data_in, bus_data_out, bus_addr_out;
  logic [15:0] wr_addr[$];
  logic [15:0] wr_data[$];
  int          failures = 0;
  int          checks = 0;

  sweep_acquisition_controller #(.VECTOR(VEC)) DUT
  (
    .ref_clk(ref_clk), .rst_b(rst_b), .src_sync(src_sync), .src_req(src_req),
    .src_word0(src_word0), .src_word1(src_word1), .src_ack(src_ack),
    .bus_busy(bus_busy), .irq(irq), .irq_ack(irq_ack), .start_addr_wr(start_addr_wr),
    .sync_word_rd(sync_word_rd), .dma_grant(dma_grant), .dma_req(dma_req),
    .bus_wr(bus_wr), .bus_data_in(bus_data_in), .bus_data_out(bus_data_out),
    .bus_data_oe_n(bus_data_oe_n), .bus_addr_out(bus_addr_out),
    .bus_addr_oe_n(bus_addr_oe_n), .err_flag(err_flag)
  );

  sac_src_model src
  (
    .ref_clk(ref_clk), .src_ack(src_ack), .src_sync(src_sync), .src_req(src_req),
    .src_word0(src_word0), .src_word1(src_word1)
  );

  // --------------------
  // clock, arbiter, memory
  // --------------------
  initial ref_clk = 1'b0;
  always #25 ref_clk = ~ref_clk;

  // arbiter grants every steal one cycle later
  always @(posedge ref_clk) dma_grant <= #1 dma_req && rst_b;

  // memory logs each write mid-cycle, where strobe and drivers have settled
  always @(negedge ref_clk)
  begin
    if (bus_wr === 1'b1)
    begin
      wr_addr.push_back(bus_addr_out);
      wr_data.push_back(bus_data_out);
      check_bit(bus_addr_oe_n, 1'b0, "address drive");
      check_bit(bus_data_oe_n, 1'b0, "data drive");
    end
  end

  // --------------------
  // helpers
  // --------------------
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string s);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask : check_word

  task automatic check_bit(input logic got, input logic exp, input string s);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t %s got %b exp %b", $time, s, got, exp);
    end
  endtask : check_bit

  // one-cycle processor strobe: 0 acknowledge, 1 start address, 2 sync word read
  // an idle edge first, so back to back pulses never touch
  task automatic proc_pulse(input int sel, input logic [15:0] d);
    @(posedge ref_clk);
    #1 bus_data_in = d;
    irq_ack       = (sel == 0);
    start_addr_wr = (sel == 1);
    sync_word_rd  = (sel == 2);
    @(posedge ref_clk);
    #1 irq_ack = 1'b0;
    start_addr_wr = 1'b0;
    sync_word_rd  = 1'b0;
  endtask : proc_pulse

  task automatic end_of_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  // --------------------
  // scenarios
  // --------------------
  task automatic test_reset();
    check_bit(irq, 1'b0, "irq in reset");
    check_bit(dma_req, 1'b0, "dma request in reset");
    check_bit(bus_data_oe_n, 1'b1, "data idle");
    check_bit(bus_addr_oe_n, 1'b1, "address idle");
    check_bit(err_flag, 1'b0, "error in reset");
    rst_b = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 $display("test reset done");
  endtask : test_reset

  task automatic test_irq();
    src.send_sync();
    check_bit(irq, 1'b1, "irq raised");
    proc_pulse(0, 16'h0000);
    check_word(bus_data_out, VEC, "vector");
    check_bit(bus_data_oe_n, 1'b0, "vector drive");
    @(posedge ref_clk);
    #1 check_bit(irq, 1'b0, "irq cleared");
    check_bit(bus_data_oe_n, 1'b1, "vector released");
    $display("test irq done");
  endtask : test_irq

  // no start address since the sync: the pair must be refused
  task automatic test_refuse();
    src.send_pair(16'h1111, 16'h2222, 0);
    check_word(16'(wr_addr.size()), 16'h0000, "refused writes");
    check_bit(err_flag, 1'b1, "error set");
    check_word(16'(src.ack_seen), 16'h0001, "refusal acknowledged");
    $display("test refuse done");
  endtask : test_refuse

  // 32 pairs fill the sweep; the 33rd crosses the 64 word limit
  task automatic test_fill();
    int k;
    src.send_sync();
    proc_pulse(0, 16'h0000);
    proc_pulse(1, BASE);
    check_bit(err_flag, 1'b0, "error cleared");
    for (k = 0; k < 32; k++)
      src.send_pair(16'hA000 + 16'(2 * k), 16'hA001 + 16'(2 * k), k % 3);
    check_word(16'(wr_addr.size()), 16'h0040, "words in sweep");
    for (k = 0; k < 64; k++)
    begin
      check_word(wr_addr[k], BASE + 16'(k), "address");
      check_word(wr_data[k], 16'hA000 + 16'(k), "stored word");
    end
    check_bit(err_flag, 1'b0, "no error at limit");
    src.send_pair(16'h5555, 16'h6666, 0);
    check_word(16'(wr_addr.size()), 16'h0040, "over limit");
    check_bit(err_flag, 1'b1, "limit error");
    check_word(16'(src.ack_seen), 16'h0022, "acknowledges given");
    $display("test fill done");
  endtask : test_fill

  // previous sweep: 31 accepted replies plus one refused
  task automatic test_sync_word();
    src.send_sync();
    bus_busy = 1'b1;
    proc_pulse(2, 16'h0000);
    check_bit(bus_data_oe_n, 1'b1, "read while busy");
    bus_busy = 1'b0;
    proc_pulse(2, 16'h0000);
    check_word(bus_data_out, 16'h8020, "sync word");
    check_bit(bus_data_oe_n, 1'b0, "sync word drive");
    proc_pulse(0, 16'h0000);
    proc_pulse(1, BASE);
    check_bit(err_flag, 1'b0, "error cleared");
    $display("test sync word done");
  endtask : test_sync_word

  // --------------------
  // main sequence and watchdog
  // --------------------
  initial
  begin
    rst_b         = 1'b0;
    bus_busy      = 1'b0;
    irq_ack       = 1'b0;
    start_addr_wr = 1'b0;
    sync_word_rd  = 1'b0;
    bus_data_in   = 16'h0000;
    repeat (5) @(posedge ref_clk);
    #1 test_reset();
    test_irq();
    test_refuse();
    test_fill();
    test_sync_word();
    end_of_test();
  end

  // a whole run needs under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    $display("ERROR %0t watchdog expired", $time);
    end_of_test();
  end
endmodule : sweep_acquisition_controller_tb
